// *** hw/prcx_pkg.sv ***
// shared constants for the priority port crossbar
package prcx_pkg;
  localparam int N_PINS       = 17;
  localparam int N_MATRIX     = 16;
  localparam int N_SLOTS      = 17;
  localparam int SLOT_W       = 5;
  // peripheral signal slots, in falling priority
  localparam logic [4:0] SL_TX    = 5'h00;
  localparam logic [4:0] SL_RX    = 5'h01;
  localparam logic [4:0] SL_SCK   = 5'h02;
  localparam logic [4:0] SL_MISO  = 5'h03;
  localparam logic [4:0] SL_MOSI  = 5'h04;
  localparam logic [4:0] SL_NSS   = 5'h05;
  localparam logic [4:0] SL_SDA   = 5'h06;
  localparam logic [4:0] SL_SCL   = 5'h07;
  localparam logic [4:0] SL_CP0   = 5'h08;
  localparam logic [4:0] SL_CP0A  = 5'h09;
  localparam logic [4:0] SL_SYSCK = 5'h0a;
  localparam logic [4:0] SL_CEX0  = 5'h0b;
  localparam logic [4:0] SL_CEX1  = 5'h0c;
  localparam logic [4:0] SL_CEX2  = 5'h0d;
  localparam logic [4:0] SL_ECI   = 5'h0e;
  localparam logic [4:0] SL_T0    = 5'h0f;
  localparam logic [4:0] SL_T1    = 5'h10;
  // fixed serial port pins
  localparam int UART_TX_PIN  = 4;
  localparam int UART_RX_PIN  = 5;
  // function_select_low fields
  localparam int FSL_UART     = 0;
  localparam int FSL_SPI      = 1;
  localparam int FSL_SMB      = 2;
  localparam int FSL_SYSCK    = 3;
  localparam int FSL_CP0      = 4;
  localparam int FSL_CP0A     = 5;
  // function_select_high fields
  localparam int FSH_PCA_LO   = 0;
  localparam int FSH_PCA_HI   = 1;
  localparam int FSH_ECI      = 3;
  localparam int FSH_T0       = 4;
  localparam int FSH_T1       = 5;
  localparam int FSH_MATRIX   = 6;
  localparam int FSH_PUD      = 7;
  // port read selects
  localparam logic [1:0] RD_PORT0 = 2'h0;
  localparam logic [1:0] RD_PORT1 = 2'h1;
  localparam logic [1:0] RD_PORT2 = 2'h2;
  // reset values
  localparam logic [16:0] LATCH_RESET = 17'h1ffff;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
endpackage

// *** hw/prcx_top.sv ***
// priority port crossbar: pin allocation, drive, pull-ups and port latches
// Summary of operation
// [R1] seventeen pins: two byte ports, one bit port
// [R2] only port 0 and port 1 take peripherals
// [R3] port read returns present pin levels
// [R4] fixed priority, lowest free pin per function
// [R5] serial port always on pins 4, 5
// [R6] assigned pins skipped for later functions
// [R7] bypass mask bits make pins skipped
// [R8] software bypasses pins used outside matrix
// [R9] software bypasses special function signal pins
// [R10] two-wire bus and serial take pin pairs
// [R11] leftover pins act as plain port pins
// [R12] slave select pin only in four-wire mode
// [R13] software follows the initialisation order
// [R14] analog pin: no pull-up, driver, receiver
// [R15] input kind 1 digital, reset digital
// [R16] drive kind per pin; two-wire bus open-drain
// [R17] pull-up on open-drain unless disabled
// [R18] pull-up off while pin drives low
// [R19] matrix off: all pins plain inputs
// [R20] matrix off: every output driver off
// [R21] read-modify-write reads latch not pins
// [R22] mask bit n controls pin n
`timescale 1ns/1ps
module prcx_top
  import prcx_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  FUNCTION_SELECT_LOW,
  input  wire logic [7:0]  FUNCTION_SELECT_HIGH,
  input  wire logic [1:0]  SLAVE_SELECT_MODE,
  input  wire logic [7:0]  BYPASS_MASK_PORT_ZERO,
  input  wire logic [7:0]  BYPASS_MASK_PORT_ONE,
  input  wire logic [7:0]  INPUT_KIND_P0,
  input  wire logic [7:0]  INPUT_KIND_P1,
  input  wire logic        INPUT_KIND_P2,
  input  wire logic [7:0]  DRIVE_KIND_P0,
  input  wire logic [7:0]  DRIVE_KIND_P1,
  input  wire logic        DRIVE_KIND_P2,
  input  wire logic [2:0]  LATCH_WR_EN,
  input  wire logic [7:0]  LATCH_WR_DATA,
  input  wire logic [1:0]  PORT_RD_SEL,
  input  wire logic        PORT_RD_RMW,
  output logic      [7:0]  PORT_RD_DATA,
  input  wire logic [16:0] PERIPH_OUT,
  input  wire logic [16:0] PERIPH_OE,
  output logic      [16:0] PERIPH_IN,
  input  wire logic [16:0] PIN_IN,
  output logic      [16:0] PIN_OUT,
  output logic      [16:0] PIN_OE,
  output logic      [16:0] PIN_PULLUP
);
  import prcx_pkg::*;

  logic [16:0]       sync1_reg;
  logic [16:0]       sync2_reg;
  logic [16:0]       sync3_reg;
  logic [16:0]       level_reg;
  logic [16:0]       latch_reg;
  logic [16:0]       slot_en;
  logic [16:0]       owner_valid_reg;
  logic [16:0]       owner_valid_next;
  logic [4:0]        owner_slot_reg  [N_PINS];
  logic [4:0]        owner_slot_next [N_PINS];
  logic [16:0]       digital;
  logic [16:0]       drive_push;
  logic [16:0]       pin_out_next;
  logic [16:0]       pin_oe_next;
  logic [16:0]       pin_pu_next;
  logic [16:0]       level_visible;
  logic              matrix_en;
  logic              pud;
  logic              four_wire;
  logic [1:0]        pca_mode;

  assign matrix_en  = FUNCTION_SELECT_HIGH[FSH_MATRIX];
  assign pud        = FUNCTION_SELECT_HIGH[FSH_PUD];
  assign four_wire  = (SLAVE_SELECT_MODE != 2'h0);
  assign pca_mode   = FUNCTION_SELECT_HIGH[FSH_PCA_HI:FSH_PCA_LO];
  // bit n of each per-port register maps to pin n of that port
  assign digital    = {INPUT_KIND_P2, INPUT_KIND_P1, INPUT_KIND_P0};   // [R22] [R15] [R1]
  assign drive_push = {DRIVE_KIND_P2, DRIVE_KIND_P1, DRIVE_KIND_P0};   // [R22]

  // per-slot requests; the serial port and two-wire bus ask as pairs
  always_comb begin
    slot_en           = 17'h00000;
    slot_en[SL_TX]    = FUNCTION_SELECT_LOW[FSL_UART];                 // [R10]
    slot_en[SL_RX]    = FUNCTION_SELECT_LOW[FSL_UART];
    slot_en[SL_SCK]   = FUNCTION_SELECT_LOW[FSL_SPI];
    slot_en[SL_MISO]  = FUNCTION_SELECT_LOW[FSL_SPI];
    slot_en[SL_MOSI]  = FUNCTION_SELECT_LOW[FSL_SPI];
    slot_en[SL_NSS]   = FUNCTION_SELECT_LOW[FSL_SPI] & four_wire;      // [R12]
    slot_en[SL_SDA]   = FUNCTION_SELECT_LOW[FSL_SMB];                  // [R10]
    slot_en[SL_SCL]   = FUNCTION_SELECT_LOW[FSL_SMB];
    slot_en[SL_CP0]   = FUNCTION_SELECT_LOW[FSL_CP0];
    slot_en[SL_CP0A]  = FUNCTION_SELECT_LOW[FSL_CP0A];
    slot_en[SL_SYSCK] = FUNCTION_SELECT_LOW[FSL_SYSCK];
    slot_en[SL_CEX0]  = (pca_mode != 2'h0);
    slot_en[SL_CEX1]  = (pca_mode[1] == 1'b1);
    slot_en[SL_CEX2]  = (pca_mode == 2'h3);
    slot_en[SL_ECI]   = FUNCTION_SELECT_HIGH[FSH_ECI];
    slot_en[SL_T0]    = FUNCTION_SELECT_HIGH[FSH_T0];
    slot_en[SL_T1]    = FUNCTION_SELECT_HIGH[FSH_T1];
  end

  // priority decoder; a chain of 16 pins per slot, so it is registered
  always_comb begin
    logic [15:0] taken;
    logic        found;
    taken = {BYPASS_MASK_PORT_ONE, BYPASS_MASK_PORT_ZERO};             // [R7] [R22]
    found = 1'b0;
    owner_valid_next = 17'h00000;
    for (int p = 0; p < N_PINS; p++) begin
      owner_slot_next[p] = 5'h00;
    end
    // serial port ignores priority and the bypass mask
    if (slot_en[SL_TX]) begin
      owner_valid_next[UART_TX_PIN] = 1'b1;                            // [R5]
      owner_slot_next[UART_TX_PIN]  = SL_TX;
      owner_valid_next[UART_RX_PIN] = 1'b1;
      owner_slot_next[UART_RX_PIN]  = SL_RX;
      taken[UART_TX_PIN]            = 1'b1;
      taken[UART_RX_PIN]            = 1'b1;
    end
    for (int s = 2; s < N_SLOTS; s++) begin
      found = 1'b0;
      if (slot_en[s]) begin
        // only the 16 port 0 / port 1 pins are searched
        for (int p = 0; p < N_MATRIX; p++) begin                       // [R2] [R4]
          if (!found && !taken[p]) begin
            owner_valid_next[p] = 1'b1;
            owner_slot_next[p]  = SLOT_W'(s);
            taken[p]            = 1'b1;                                // [R6]
            found               = 1'b1;
          end
        end
      end
    end
  end

  // owner map; unowned pins fall back to the port latch
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      owner_valid_reg <= 17'h00000;
      for (int p = 0; p < N_PINS; p++) begin
        owner_slot_reg[p] <= 5'h00;
      end
    end else begin
      owner_valid_reg <= owner_valid_next;                             // [R11]
      for (int p = 0; p < N_PINS; p++) begin
        owner_slot_reg[p] <= owner_slot_next[p];
      end
    end
  end

  // per-pin driver, pull-up and receiver logic
  genvar gp;
  generate
    for (gp = 0; gp < N_PINS; gp++) begin : g_pin
      logic       owned;
      logic [4:0] slot;
      logic       val;
      logic       driving;
      logic       od;
      assign owned   = matrix_en & owner_valid_reg[gp];                // [R19]
      assign slot    = owner_slot_reg[gp];
      assign val     = owned ? (PERIPH_OE[slot] ? PERIPH_OUT[slot] : 1'b1)
                             : latch_reg[gp];
      assign driving = owned ? PERIPH_OE[slot] : 1'b1;
      // two-wire bus pins are open-drain whatever drive kind says
      assign od      = !drive_push[gp] | (owned & ((slot == SL_SDA) | (slot == SL_SCL))); // [R16]
      // no driver at all while the matrix is off or the pin is analog
      assign pin_oe_next[gp]  = matrix_en & digital[gp] & driving & (od ? !val : 1'b1); // [R20] [R14]
      assign pin_out_next[gp] = val;
      // pull-up only on open-drain, dropped while pulling low to save current
      assign pin_pu_next[gp]  = digital[gp] & od & !pud & !(pin_oe_next[gp] & !val); // [R17] [R18]
      // analog pins have the receiver off and read as zero
      assign level_visible[gp] = level_reg[gp] & digital[gp];          // [R14]
    end
  endgenerate

  // registered pin drive
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PIN_OUT    <= 17'h1ffff;
      PIN_OE     <= 17'h00000;
      PIN_PULLUP <= 17'h1ffff;
    end else begin
      PIN_OUT    <= pin_out_next;
      PIN_OE     <= pin_oe_next;
      PIN_PULLUP <= pin_pu_next;
    end
  end

  // pin synchroniser; level moves only once stages 2 and 3 agree
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= 17'h1ffff;
      sync2_reg <= 17'h1ffff;
      sync3_reg <= 17'h1ffff;
      level_reg <= 17'h1ffff;
    end else begin
      sync1_reg <= PIN_IN;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int p = 0; p < N_PINS; p++) begin
        if (sync2_reg[p] == sync3_reg[p]) begin
          level_reg[p] <= sync3_reg[p];
        end
      end
    end
  end

  // peripheral inputs see their pin; idle high when not placed
  always_comb begin
    PERIPH_IN = 17'h1ffff;
    for (int p = 0; p < N_PINS; p++) begin
      if (matrix_en && owner_valid_reg[p]) begin
        PERIPH_IN[owner_slot_reg[p]] = level_visible[p];
      end
    end
  end

  // port output latches, written a byte at a time
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      latch_reg <= LATCH_RESET;
    end else begin
      if (LATCH_WR_EN[0]) begin
        latch_reg[7:0] <= LATCH_WR_DATA;
      end
      if (LATCH_WR_EN[1]) begin
        latch_reg[15:8] <= LATCH_WR_DATA;
      end
      if (LATCH_WR_EN[2]) begin
        latch_reg[16] <= LATCH_WR_DATA[0];
      end
    end
  end

  // port read: pin levels, or latch for read-modify-write
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PORT_RD_DATA <= BYTE_ZERO;
    end else begin
      case (PORT_RD_SEL)
        RD_PORT0: PORT_RD_DATA <= PORT_RD_RMW ? latch_reg[7:0] : level_visible[7:0];   // [R21] [R3]
        RD_PORT1: PORT_RD_DATA <= PORT_RD_RMW ? latch_reg[15:8] : level_visible[15:8];
        RD_PORT2: PORT_RD_DATA <= {7'h00, PORT_RD_RMW ? latch_reg[16] : level_visible[16]};
        default:  PORT_RD_DATA <= BYTE_ZERO;
      endcase
    end
  end

  // checks
  sequence s_matrix_on2;
    matrix_en [*2];
  endsequence

  property p_off_no_drive;
    @(posedge CLOCK) disable iff (!RST_N) !matrix_en |=> (PIN_OE == 17'h00000);
  endproperty
  a_off_no_drive: assert property (p_off_no_drive) else $error("driver on with matrix off"); // [R20]

  property p_uart_fixed;
    @(posedge CLOCK) disable iff (!RST_N)
      (FUNCTION_SELECT_LOW[FSL_UART] [*2]) and s_matrix_on2 |->
        owner_valid_reg[UART_TX_PIN] && (owner_slot_reg[UART_TX_PIN] == SL_TX)
        && (owner_slot_reg[UART_RX_PIN] == SL_RX);
  endproperty
  a_uart_fixed: assert property (p_uart_fixed) else $error("serial port not on 4/5"); // [R5]

  property p_analog_quiet;
    @(posedge CLOCK) disable iff (!RST_N)
      !INPUT_KIND_P0[0] |=> !PIN_OE[0] && !PIN_PULLUP[0];
  endproperty
  a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin active"); // [R14]

  property p_bypass_respected;
    @(posedge CLOCK) disable iff (!RST_N)
      !$past(FUNCTION_SELECT_LOW[FSL_UART]) |->
        ((owner_valid_reg[15:0] & $past({BYPASS_MASK_PORT_ONE, BYPASS_MASK_PORT_ZERO})) == 16'h0000);
  endproperty
  a_bypass_respected: assert property (p_bypass_respected) else $error("bypassed pin owned"); // [R7]

  property p_bit_port_free;
    @(posedge CLOCK) disable iff (!RST_N) !owner_valid_reg[16];
  endproperty
  a_bit_port_free: assert property (p_bit_port_free) else $error("bit port owned"); // [R2]

  property p_low_no_pullup;
    @(posedge CLOCK) disable iff (!RST_N)
      ((PIN_OE & ~PIN_OUT & PIN_PULLUP) == 17'h00000);
  endproperty
  a_low_no_pullup: assert property (p_low_no_pullup) else $error("pull-up on low pin"); // [R18]

  property p_pud_off;
    @(posedge CLOCK) disable iff (!RST_N) pud |=> (PIN_PULLUP == 17'h00000);
  endproperty
  a_pud_off: assert property (p_pud_off) else $error("pull-up with disable set"); // [R17]

  property p_rmw_latch;
    @(posedge CLOCK) disable iff (!RST_N)
      PORT_RD_RMW && (PORT_RD_SEL == RD_PORT1) |=> PORT_RD_DATA == $past(latch_reg[15:8]);
  endproperty
  a_rmw_latch: assert property (p_rmw_latch) else $error("rmw read not latch"); // [R21]

  // pins whose recorded owner is the slave select slot
  function automatic logic [16:0] nss_pin_mask();
    logic [16:0] m;
    m = 17'h00000;
    for (int p = 0; p < N_PINS; p++) begin
      m[p] = (owner_slot_reg[p] == SL_NSS);
    end
    return m;
  endfunction

  property p_three_wire;
    @(posedge CLOCK) disable iff (!RST_N)
      (SLAVE_SELECT_MODE == 2'h0) |=> !(|(owner_valid_reg & nss_pin_mask()));
  endproperty
  a_three_wire: assert property (p_three_wire) else $error("slave select placed"); // [R12]

  // peripherals must see an idle level while the matrix is off
  property p_periph_idle;
    @(posedge CLOCK) disable iff (!RST_N) !matrix_en |-> (PERIPH_IN == 17'h1ffff);
  endproperty
  a_periph_idle: assert property (p_periph_idle) else $error("peripheral input with matrix off"); // [R19]

  // the serial pair is always placed together
  property p_uart_pair;
    @(posedge CLOCK) disable iff (!RST_N)
      owner_valid_reg[UART_TX_PIN] && (owner_slot_reg[UART_TX_PIN] == SL_TX) |->
        owner_valid_reg[UART_RX_PIN] && (owner_slot_reg[UART_RX_PIN] == SL_RX);
  endproperty
  a_uart_pair: assert property (p_uart_pair) else $error("serial pair split"); // [R10]

  // pin 0, while it holds the two-wire data slot, may pull low but never drive high
  property p_smb_open_drain;
    @(posedge CLOCK) disable iff (!RST_N)
      $past(matrix_en && owner_valid_reg[0] && (owner_slot_reg[0] == SL_SDA)) |->
        !(PIN_OE[0] && PIN_OUT[0]);
  endproperty
  a_smb_open_drain: assert property (p_smb_open_drain) else $error("two-wire pin driven high"); // [R16]
endmodule

// *** sim/prcx_pins.sv ***
// pad model for the far side: resolves each pin level
`timescale 1ns/1ps
module prcx_pins (
  input  wire logic        clk,
  input  wire logic [16:0] pin_out,
  input  wire logic [16:0] pin_oe,
  input  wire logic [16:0] pin_pullup,
  input  wire logic [16:0] ext_val,
  input  wire logic [16:0] ext_en,
  output logic      [16:0] pad
);
  logic [16:0] float_reg = 17'h0aaaa;
  // a floating pad wanders so a stale level never passes for a driven one
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  // device driver first, then the outside driver, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 17; i++) begin
      if (pin_oe[i])
        pad[i] = pin_out[i];
      else if (ext_en[i])
        pad[i] = ext_val[i];
      else if (pin_pullup[i])
        pad[i] = 1'b1;
      else
        pad[i] = float_reg[i];
    end
  end
endmodule

// *** sim/prcx_top_test.sv ***
// self-checking bench for the priority port crossbar
`timescale 1ns/1ps
module prcx_top_test;
  import prcx_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] fsl = 8'h00, fsh = 8'h00, byp0 = 8'h00, ik0 = 8'hff, dk0 = 8'h00;
  logic [1:0] ssm = 2'h0, rsel = 2'h0;
  logic [2:0] lwe = 3'h0;
  logic [7:0] lwd = 8'h00, rd;
  logic rrmw = 1'b0;
  logic [16:0] pout = 17'h0, poe = 17'h0, pin_in, pin_out, pin_oe, pin_pu;
  logic [16:0] ext_val = 17'h0, ext_en = 17'h0, periph_in;
  int fail_count = 0;
  int num_checks = 0;
  prcx_top dut (.CLOCK(CLOCK), .RST_N(RST_N), .FUNCTION_SELECT_LOW(fsl),
    .FUNCTION_SELECT_HIGH(fsh), .SLAVE_SELECT_MODE(ssm), .BYPASS_MASK_PORT_ZERO(byp0),
    .BYPASS_MASK_PORT_ONE(8'h00), .INPUT_KIND_P0(ik0), .INPUT_KIND_P1(8'hff),
    .INPUT_KIND_P2(1'b1), .DRIVE_KIND_P0(dk0), .DRIVE_KIND_P1(8'h00),
    .DRIVE_KIND_P2(1'b0), .LATCH_WR_EN(lwe), .LATCH_WR_DATA(lwd), .PORT_RD_SEL(rsel),
    .PORT_RD_RMW(rrmw), .PORT_RD_DATA(rd), .PERIPH_OUT(pout), .PERIPH_OE(poe),
    .PERIPH_IN(periph_in), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PIN_PULLUP(pin_pu));
  prcx_pins pins (.clk(CLOCK), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .ext_val(ext_val), .ext_en(ext_en), .pad(pin_in));
  // 50 ns system clock
  initial begin
    forever #25 CLOCK = ~CLOCK;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp17(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: pins got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: read got %h expected %h", $time, got, exp);
    end
  endtask
  // config settles in two edges; three leaves margin
  task automatic cfg(input logic [7:0] l, input logic [7:0] h, input logic [7:0] b0);
    @(posedge CLOCK);
    fsl <= l;
    fsh <= h;
    byp0 <= b0;
    repeat (3) @(posedge CLOCK);
    #1;
  endtask
  task automatic latch(input logic [2:0] en, input logic [7:0] d);
    @(posedge CLOCK);
    lwe <= en;
    lwd <= d;
    @(posedge CLOCK);
    lwe <= 3'h0;
    repeat (3) @(posedge CLOCK);
    #1;
  endtask
  // open-drain pins: only the slot pulling low drives, so oe shows its pin
  task automatic map(input logic [4:0] s, input int p);
    logic [16:0] e;
    e = (p < 0) ? 17'h0 : 17'h1 << p;
    @(posedge CLOCK);
    poe <= 17'h1 << s;
    repeat (3) @(posedge CLOCK);
    #1;
    cmp17(pin_oe, e);
    cmp17(pin_pu, ~e);
  endtask
  task automatic t_off();
    cfg(8'h02, 8'h00, 8'h00);
    latch(3'h1, 8'h00);
    cmp17(pin_oe, 17'h0);
    cmp17(pin_out & 17'h000ff, 17'h0);
    cfg(8'h02, 8'h40, 8'h00);
    cmp17(pin_oe, 17'h000f8);
    latch(3'h1, 8'hff);
    $display("test matrix enable done");
  endtask
  task automatic t_alloc();
    poe <= 17'h0;
    cfg(8'h02, 8'h40, 8'h00);
    map(SL_SCK, 0);
    map(SL_MOSI, 2);
    map(SL_NSS, -1);
    ssm <= 2'h1;
    map(SL_NSS, 3);
    cfg(8'h07, 8'h40, 8'h0c);
    map(SL_TX, UART_TX_PIN);
    map(SL_RX, UART_RX_PIN);
    map(SL_MISO, 1);
    map(SL_MOSI, 6);
    map(SL_SDA, 8);
    map(SL_SCL, 9);
    cfg(8'h02, 8'h40, 8'hff);
    map(SL_SCK, 8);
    $display("test allocation done");
  endtask
  task automatic t_drive();
    dk0 <= 8'hff;
    pout <= 17'h1 << SL_SDA;
    poe <= 17'h1 << SL_SDA;
    cfg(8'h04, 8'h40, 8'h00);
    cmp17(pin_oe & 17'h7, 17'h4);
    cmp17(pin_pu & 17'h7, 17'h3);
    cfg(8'h04, 8'hc0, 8'h00);
    cmp17(pin_pu & 17'h7, 17'h0);
    ik0 <= 8'hfb;
    cfg(8'h00, 8'h40, 8'h04);
    cmp17(pin_oe & 17'h4, 17'h0);
    cmp17(pin_pu & 17'h4, 17'h0);
    $display("test drive kinds done");
  endtask
  task automatic t_read();
    ext_val <= 17'h1a53c;
    ext_en <= 17'h1ffff;
    rsel <= RD_PORT1;
    cfg(8'h00, 8'h00, 8'h00);
    repeat (4) @(posedge CLOCK);
    #1;
    cmp8(rd, 8'ha5);
    rsel <= RD_PORT2;
    latch(3'h2, 8'h96);
    cmp8(rd, 8'h01);
    cmp17(periph_in, 17'h1ffff);
    rrmw <= 1'b1;
    rsel <= RD_PORT1;
    repeat (2) @(posedge CLOCK);
    #1;
    cmp8(rd, 8'h96);
    cfg(8'h04, 8'h40, 8'h00);
    cmp17(periph_in, 17'h1ff3f);
    cmp17(pin_out & 17'h3, 17'h3);
    $display("test port read done");
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge CLOCK);
    #1;
    cmp17(pin_oe, 17'h0);
    cmp17(pin_pu, 17'h1ffff);
    RST_N <= 1'b1;
    t_off();
    t_alloc();
    t_drive();
    t_read();
    stop_test();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge CLOCK);
    fail_count++;
    stop_test();
  end
endmodule
